// ===== hw/tcs_pkg.sv
package tcs_pkg;

    // ---------------------------------------------------------------
    // Command conditions
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {COND_NEVER, COND_ALWAYS, COND_PATTERN} cond_t;
    typedef enum logic [1:0] {CNT_NONE, CNT_EQ, CNT_GT, CNT_GE} cnt_mode_t;

    // ---------------------------------------------------------------
    // Command indices and command word layout
    // ---------------------------------------------------------------
    localparam int CMD_STOP   = 0;
    localparam int CMD_RET    = 1;
    localparam int CMD_ADV    = 2;
    localparam int CMD_TRACE  = 3;
    localparam int NUM_CMDS   = 4;
    localparam int CMD_FLD_W  = 4;
    localparam int CMD_WORD_W = NUM_CMDS * CMD_FLD_W;
    localparam int COND_LSB   = 0;
    localparam int CNT_LSB    = 2;

    // ---------------------------------------------------------------
    // Program port selectors
    // ---------------------------------------------------------------
    localparam logic [3:0] SEL_CMD   = 4'h0;
    localparam logic [3:0] SEL_DELAY = 4'h1;
    localparam logic [3:0] SEL_VALUE = 4'h2;
    localparam logic [3:0] SEL_MASK  = 4'h6;

    // ---------------------------------------------------------------
    // Reset values and timing
    // ---------------------------------------------------------------
    localparam logic [CMD_WORD_W-1:0] CMD_RESET = 16'h0000;
    localparam int EVAL_CYCLES   = 2;
    localparam int DEFAULT_DELAY = 512;

endpackage

// ===== hw/cmd_if.sv
`timescale 1ns/1ps
interface cmd_if #(
    parameter int DATA_W = 32,
    parameter int CNT_W  = 17
);
    logic [1:0]        cond;
    logic [1:0]        cnt_mode;
    logic [DATA_W-1:0] value;
    logic [DATA_W-1:0] mask;
    logic [DATA_W-1:0] sample;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  delay;
    logic              hit;

    modport ctrl (output cond, cnt_mode, value, mask, sample, count, delay, input hit);
    modport eval (input cond, cnt_mode, value, mask, sample, count, delay, output hit);
endinterface

// ===== hw/cmd_eval.sv
`timescale 1ns/1ps
module cmd_eval (
    cmd_if.eval c
);
    // ---------------------------------------------------------------
    // Pattern and count tests
    // ---------------------------------------------------------------
    // Mask bit set means the sample bit is compared; all clear is don't care
    wire pat_ok = ((c.sample ^ c.value) & c.mask) == '0;
    wire eq_ok  = c.count == c.delay;
    wire gt_ok  = c.count > c.delay;
    wire cnt_ok = (c.cnt_mode == tcs_pkg::CNT_EQ) ? eq_ok :
                  (c.cnt_mode == tcs_pkg::CNT_GT) ? gt_ok :
                  (c.cnt_mode == tcs_pkg::CNT_GE) ? (gt_ok | eq_ok) :
                  1'b1;
    wire cond_ok = (c.cond == tcs_pkg::COND_ALWAYS) ||
                   ((c.cond == tcs_pkg::COND_PATTERN) && pat_ok);

    assign c.hit = cond_ok & cnt_ok;
endmodule

// ===== hw/trace_control_sequencer.sv
`timescale 1ns/1ps
module trace_control_sequencer #(
    parameter int NUM_LEVELS = 16,
    parameter int LVL_W      = 4,
    parameter int DATA_W     = 32,
    parameter int CNT_W      = 17,
    parameter int ADDR_W     = 9
) (
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    input  wire logic              ARM,
    input  wire logic              CFG_WE,
    input  wire logic [LVL_W-1:0]  CFG_LEVEL,
    input  wire logic [3:0]        CFG_SEL,
    input  wire logic [31:0]       CFG_WDATA,
    input  wire logic              SAMPLE_CLK,
    input  wire logic [DATA_W-1:0] SAMPLE_DATA,
    output logic                   MEM_WE,
    output logic [ADDR_W-1:0]      MEM_ADDR,
    output logic [DATA_W-1:0]      MEM_WDATA,
    output logic                   RUNNING,
    output logic                   HALT,
    output logic [LVL_W-1:0]       LEVEL,
    output logic [CNT_W-1:0]       LEVEL_COUNT
);
    localparam int NC = tcs_pkg::NUM_CMDS;

    // ---------------------------------------------------------------
    // Level program store
    // ---------------------------------------------------------------
    logic [tcs_pkg::CMD_WORD_W-1:0] cmd_mem   [NUM_LEVELS];
    logic [CNT_W-1:0]               delay_mem [NUM_LEVELS];
    logic [DATA_W-1:0]              value_mem [NUM_LEVELS][NC];
    logic [DATA_W-1:0]              mask_mem  [NUM_LEVELS][NC];

    wire       wr_cmd   = CFG_WE && (CFG_SEL == tcs_pkg::SEL_CMD);
    wire       wr_delay = CFG_WE && (CFG_SEL == tcs_pkg::SEL_DELAY);
    wire       wr_value = CFG_WE && (CFG_SEL >= tcs_pkg::SEL_VALUE) &&
                          (CFG_SEL < tcs_pkg::SEL_MASK);
    wire       wr_mask  = CFG_WE && (CFG_SEL >= tcs_pkg::SEL_MASK) &&
                          (CFG_SEL < tcs_pkg::SEL_MASK + 4'(NC));
    wire [1:0] wr_vidx  = 2'(CFG_SEL - tcs_pkg::SEL_VALUE);
    wire [1:0] wr_midx  = 2'(CFG_SEL - tcs_pkg::SEL_MASK);

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            for (int l = 0; l < NUM_LEVELS; l++) begin
                cmd_mem[l]   <= tcs_pkg::CMD_RESET;
                delay_mem[l] <= CNT_W'(tcs_pkg::DEFAULT_DELAY);
                for (int k = 0; k < NC; k++) begin
                    value_mem[l][k] <= '0;
                    mask_mem[l][k]  <= '0;
                end
            end
        end else begin
            if (wr_cmd) begin
                cmd_mem[CFG_LEVEL] <= CFG_WDATA[tcs_pkg::CMD_WORD_W-1:0];
            end
            if (wr_delay) begin
                delay_mem[CFG_LEVEL] <= CFG_WDATA[CNT_W-1:0];
            end
            if (wr_value) begin
                value_mem[CFG_LEVEL][wr_vidx] <= CFG_WDATA[DATA_W-1:0];
            end
            if (wr_mask) begin
                mask_mem[CFG_LEVEL][wr_midx] <= CFG_WDATA[DATA_W-1:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Sample clock and data synchronisers
    // ---------------------------------------------------------------
    // Data is sampled with the clock; it must hold steady for a few
    // system cycles around each sample clock edge.
    logic              sclk_meta_reg;
    logic              sclk_sync_reg;
    logic              sclk_prev_reg;
    logic [DATA_W-1:0] data_meta_reg;
    logic [DATA_W-1:0] data_sync_reg;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            sclk_meta_reg <= 1'b0;
            sclk_sync_reg <= 1'b0;
            sclk_prev_reg <= 1'b0;
            data_meta_reg <= '0;
            data_sync_reg <= '0;
        end else begin
            sclk_meta_reg <= SAMPLE_CLK;
            sclk_sync_reg <= sclk_meta_reg;
            sclk_prev_reg <= sclk_sync_reg;
            data_meta_reg <= SAMPLE_DATA;
            data_sync_reg <= data_meta_reg;
        end
    end

    wire sclk_edge = sclk_sync_reg && !sclk_prev_reg;

    // ---------------------------------------------------------------
    // Sequencer state
    // ---------------------------------------------------------------
    logic              run_reg;
    logic              halt_reg;
    logic [LVL_W-1:0]  level_reg;
    logic [CNT_W-1:0]  count_reg;
    logic [DATA_W-1:0] samp_reg;
    logic [DATA_W-1:0] samp2_reg;
    logic              v1_reg;
    logic              v2_reg;
    logic [NC-1:0]     hits_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [NC-1:0]     hits;

    // ---------------------------------------------------------------
    // Condition evaluators, one per command of the active level
    // ---------------------------------------------------------------
    wire [tcs_pkg::CMD_WORD_W-1:0] cur_cmd = cmd_mem[level_reg];
    // Count seen by the evaluators includes the sample being judged
    wire [CNT_W-1:0] eval_count = (count_reg == '1) ? count_reg : count_reg + 1'b1;

    for (genvar i = 0; i < NC; i++) begin : g_cmd
        localparam int B = i * tcs_pkg::CMD_FLD_W;
        cmd_if #(.DATA_W(DATA_W), .CNT_W(CNT_W)) cif ();
        assign cif.cond     = cur_cmd[B + tcs_pkg::COND_LSB +: 2];
        assign cif.cnt_mode = cur_cmd[B + tcs_pkg::CNT_LSB +: 2];
        assign cif.value    = value_mem[level_reg][i];
        assign cif.mask     = mask_mem[level_reg][i];
        assign cif.sample   = samp_reg;
        assign cif.count    = eval_count;
        assign cif.delay    = delay_mem[level_reg];
        assign hits[i]      = cif.hit;
        cmd_eval u_eval (
            .c (cif.eval)
        );
    end

    // ---------------------------------------------------------------
    // Decisions at the end of the second evaluation cycle
    // ---------------------------------------------------------------
    wire last_level = level_reg == LVL_W'(NUM_LEVELS - 1);
    wire stop_now   = v2_reg && hits_reg[tcs_pkg::CMD_STOP] && !ARM;
    wire ret_now    = v2_reg && !hits_reg[tcs_pkg::CMD_STOP] &&
                      hits_reg[tcs_pkg::CMD_RET] && !ARM;
    wire adv_now    = v2_reg && !hits_reg[tcs_pkg::CMD_STOP] &&
                      !hits_reg[tcs_pkg::CMD_RET] &&
                      hits_reg[tcs_pkg::CMD_ADV] && !last_level && !ARM;
    wire store_now  = v2_reg && hits_reg[tcs_pkg::CMD_TRACE] && !ARM;
    wire take_samp  = sclk_edge && run_reg;
    wire enter_lvl  = ARM || ret_now || adv_now;

    wire [LVL_W-1:0] level_next =
        (ARM || ret_now) ? '0 :
        adv_now          ? level_reg + 1'b1 :
        level_reg;
    wire [CNT_W-1:0] count_next =
        enter_lvl ? '0 :
        v2_reg    ? eval_count :
        count_reg;
    // Arming rewinds the pointer but leaves old contents in place
    wire [ADDR_W-1:0] addr_next =
        ARM       ? '0 :
        store_now ? addr_reg + 1'b1 :
        addr_reg;

    // ---------------------------------------------------------------
    // Evaluation pipeline
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            samp_reg  <= '0;
            samp2_reg <= '0;
            v1_reg    <= 1'b0;
            v2_reg    <= 1'b0;
            hits_reg  <= '0;
        end else begin
            // After a halt the register still shifts once, unevaluated
            if (take_samp) begin
                samp_reg <= data_sync_reg;
            end
            v1_reg    <= take_samp && !halt_reg && !ARM;
            v2_reg    <= v1_reg && !ARM;
            hits_reg  <= hits;
            samp2_reg <= samp_reg;
        end
    end

    // ---------------------------------------------------------------
    // Run control, level, count and memory write
    // ---------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            run_reg   <= 1'b0;
            halt_reg  <= 1'b0;
            level_reg <= '0;
            count_reg <= '0;
            addr_reg  <= '0;
            MEM_WE    <= 1'b0;
            MEM_ADDR  <= '0;
            MEM_WDATA <= '0;
        end else begin
            if (ARM) begin
                run_reg  <= 1'b1;
                halt_reg <= 1'b0;
            end else begin
                if (stop_now) begin
                    halt_reg <= 1'b1;
                end
                if (halt_reg && take_samp) begin
                    run_reg <= 1'b0;
                end
            end
            level_reg <= level_next;
            count_reg <= count_next;
            addr_reg  <= addr_next;
            MEM_WE    <= store_now;
            MEM_ADDR  <= addr_reg;
            MEM_WDATA <= samp2_reg;
        end
    end

    assign RUNNING     = run_reg;
    assign HALT        = halt_reg;
    assign LEVEL       = level_reg;
    assign LEVEL_COUNT = count_reg;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_eval_two_cycles: assert property (
        take_samp && !halt_reg && !ARM ##1 !ARM |-> ##1 v2_reg
    ) else $error("sample not evaluated two cycles after it was taken");

    a_stop_halts: assert property (
        v2_reg && hits_reg[tcs_pkg::CMD_STOP] && !ARM |=> HALT && RUNNING
    ) else $error("stop condition did not raise halt");

    a_return_zero: assert property (
        ret_now |=> LEVEL == '0 && LEVEL_COUNT == '0
    ) else $error("return did not reach level zero with cleared count");

    a_advance_next: assert property (
        adv_now |=> LEVEL == $past(level_reg) + 1'b1 && LEVEL_COUNT == '0
    ) else $error("advance did not enter next level with cleared count");

    a_stop_first: assert property (
        stop_now |=> LEVEL == $past(level_reg) && HALT
    ) else $error("stop lost priority over return or advance");

    a_trace_store: assert property (
        store_now |=> MEM_WE && MEM_ADDR == $past(addr_reg) &&
                      MEM_WDATA == $past(samp2_reg)
    ) else $error("traced sample not written to memory");

    a_no_trace_store: assert property (
        !(v2_reg && hits_reg[tcs_pkg::CMD_TRACE]) |=> !MEM_WE
    ) else $error("memory written without a trace decision");

    a_arm_restart: assert property (
        ARM |=> RUNNING && !HALT && !MEM_WE && LEVEL == '0 ##1 MEM_ADDR == '0
    ) else $error("arming did not restart at level zero and address zero");

    a_halt_next_edge: assert property (
        HALT && take_samp && !ARM |=> !RUNNING && !v1_reg
    ) else $error("halt not taken at the next sample clock");

    a_halted_quiet: assert property (
        !RUNNING && !ARM |=> !RUNNING ##2 !MEM_WE
    ) else $error("memory written after recording ended");

    a_addr_step: assert property (
        MEM_WE |=> MEM_ADDR == $past(MEM_ADDR) + 1'b1
    ) else $error("write pointer did not step after a store");

    a_count_entry: assert property (
        enter_lvl |=> LEVEL_COUNT == '0
    ) else $error("level count not cleared on level entry");

    a_count_judged: assert property (
        v2_reg && !enter_lvl |=> LEVEL_COUNT == $past(eval_count)
    ) else $error("judged sample not added to the level count");

    a_level_steady: assert property (
        !v2_reg && !ARM |=> LEVEL == $past(level_reg) && LEVEL_COUNT == $past(count_reg)
    ) else $error("level or count moved outside a decision");

    a_arm_flush: assert property (
        ARM |=> !v1_reg && !v2_reg
    ) else $error("sample in flight survived arming");

    a_halt_stands: assert property (
        HALT && !ARM |=> HALT
    ) else $error("halt dropped without arming");

    a_sample_shift: assert property (
        take_samp |=> samp_reg == $past(data_sync_reg)
    ) else $error("sample register did not shift on a sample clock");

    a_trace_indep: assert property (
        v2_reg && hits_reg[tcs_pkg::CMD_STOP] && hits_reg[tcs_pkg::CMD_TRACE] &&
        !ARM |=> MEM_WE && HALT
    ) else $error("stop suppressed the trace decision of its sample");

endmodule

// ===== verification/sut_model.sv
`timescale 1ns/1ps
module sut_model (
    input  wire logic        CLK_SYS,
    output logic             SAMPLE_CLK,
    output logic [31:0]      SAMPLE_DATA
);
    // ---------------------------------------------------------------
    // Probed system: one sample clock pulse per call
    // ---------------------------------------------------------------
    initial begin
        SAMPLE_CLK  = 1'b0;
        SAMPLE_DATA = 32'h00000000;
    end

    // Data settles 4 cycles before the edge and holds 4 after it, so the
    // two-flop synchronisers never catch it moving; afterwards it is
    // inverted so a stale value can never pass for a fresh one
    task automatic send(input logic [31:0] d);
        @(posedge CLK_SYS);
        #1 SAMPLE_DATA = d;
        repeat (4) @(posedge CLK_SYS);
        #1 SAMPLE_CLK = 1'b1;
        repeat (4) @(posedge CLK_SYS);
        #1 SAMPLE_DATA = ~d;
        repeat (2) @(posedge CLK_SYS);
        #1 SAMPLE_CLK = 1'b0;
        repeat (2) @(posedge CLK_SYS);
    endtask
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    // ---------------------------------------------------------------
    // Signals and instances
    // ---------------------------------------------------------------
    logic        CLK_SYS;
    logic        RST_N;
    logic        ARM;
    logic        CFG_WE;
    logic [3:0]  CFG_LEVEL;
    logic [3:0]  CFG_SEL;
    logic [31:0] CFG_WDATA;
    logic        SAMPLE_CLK;
    logic [31:0] SAMPLE_DATA;
    logic        MEM_WE;
    logic [8:0]  MEM_ADDR;
    logic [31:0] MEM_WDATA;
    logic        RUNNING;
    logic        HALT;
    logic [3:0]  LEVEL;
    logic [16:0] LEVEL_COUNT;
    logic [31:0] mem [512];
    int          stores;
    int          fail_count;
    int          n_checks;
    localparam logic [31:0] EVT = 32'hEEEE0001;
    localparam logic [31:0] XR  = 32'hAAAA0002;
    localparam logic [31:0] YS  = 32'h55550003;

    trace_control_sequencer u_trace_control_sequencer (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .ARM(ARM), .CFG_WE(CFG_WE),
        .CFG_LEVEL(CFG_LEVEL), .CFG_SEL(CFG_SEL), .CFG_WDATA(CFG_WDATA),
        .SAMPLE_CLK(SAMPLE_CLK), .SAMPLE_DATA(SAMPLE_DATA), .MEM_WE(MEM_WE),
        .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .RUNNING(RUNNING),
        .HALT(HALT), .LEVEL(LEVEL), .LEVEL_COUNT(LEVEL_COUNT));
    sut_model u_sut_model (.CLK_SYS(CLK_SYS), .SAMPLE_CLK(SAMPLE_CLK),
        .SAMPLE_DATA(SAMPLE_DATA));

    initial begin
        CLK_SYS = 1'b0;
        forever #2 CLK_SYS = ~CLK_SYS;
    end

    // Acquisition memory image; never cleared, as in the real store
    always @(posedge CLK_SYS) begin
        if (MEM_WE === 1'b1) begin
            mem[MEM_ADDR] = MEM_WDATA;
            stores = stores + 1;
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks = n_checks + 1;
        if (g !== e) begin
            fail_count = fail_count + 1;
            $display("unexpected %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    function automatic logic [3:0] f(input tcs_pkg::cond_t c, input tcs_pkg::cnt_mode_t m);
        return {m, c};
    endfunction

    task automatic cfg(input logic [3:0] lvl, input logic [3:0] sel, input logic [31:0] d);
        @(posedge CLK_SYS);
        #1 CFG_WE = 1'b1;
        CFG_LEVEL = lvl;
        CFG_SEL = sel;
        CFG_WDATA = d;
        @(posedge CLK_SYS);
        #1 CFG_WE = 1'b0;
    endtask

    // Command word is {trace, advance, return, stop}
    task automatic lv(input logic [3:0] lvl, input logic [15:0] c, input logic [31:0] dly);
        cfg(lvl, tcs_pkg::SEL_CMD, {16'h0000, c});
        cfg(lvl, tcs_pkg::SEL_DELAY, dly);
    endtask

    task automatic pt(input logic [3:0] lvl, input int i, input logic [31:0] v);
        cfg(lvl, tcs_pkg::SEL_VALUE + 4'(i), v);
        cfg(lvl, tcs_pkg::SEL_MASK + 4'(i), 32'hFFFFFFFF);
    endtask

    // Three idle cycles after release cover the synchroniser history
    task automatic do_reset;
        @(posedge CLK_SYS);
        #1 RST_N = 1'b0;
        repeat (12) @(posedge CLK_SYS);
        #1 RST_N = 1'b1;
        repeat (3) @(posedge CLK_SYS);
    endtask

    task automatic arm;
        @(posedge CLK_SYS);
        #1 ARM = 1'b1;
        stores = 0;
        @(posedge CLK_SYS);
        #1 ARM = 1'b0;
        chk("running", 1, RUNNING);
    endtask

    task automatic st(input int n, input logic [31:0] b);
        for (int i = 0; i < n; i++) begin
            u_sut_model.send(b + 32'(i));
        end
    endtask

    initial begin
        repeat (100000) @(posedge CLK_SYS);
        fail_count = fail_count + 1;
        $display("unexpected run_length expected finished seen cycle_limit");
        summarize();
    end

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        RST_N = 1'b0;
        ARM = 1'b0;
        CFG_WE = 1'b0;
        CFG_LEVEL = 4'h0;
        CFG_SEL = 4'h0;
        CFG_WDATA = 32'h00000000;
        fail_count = 0;
        n_checks = 0;
        stores = 0;
        // Fill memory: stop on count above 512, one extra sample shifted
        do_reset();
        lv(0, {f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE), 8'h00,
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_GT)}, 512);
        arm();
        st(512, 32'h10000000);
        chk("halt_early", 0, HALT);
        st(3, 32'h10000200);
        chk("fill_stores", 513, stores);
        chk("fill_halt", 1, HALT);
        chk("fill_running", 0, RUNNING);
        chk("fill_wrap", 32'h10000200, mem[0]);
        chk("fill_last", 32'h100001FF, mem[511]);
        // Stored event first, then store all until count equals 511
        do_reset();
        lv(0, {f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE),
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE), 8'h00}, 515);
        pt(0, tcs_pkg::CMD_ADV, EVT);
        pt(0, tcs_pkg::CMD_TRACE, EVT);
        lv(1, {f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE), 8'h00,
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_EQ)}, 511);
        arm();
        st(3, 32'h20000100);
        chk("wait_stores", 0, stores);
        chk("wait_level", 0, LEVEL);
        st(1, EVT);
        chk("event_level", 1, LEVEL);
        chk("event_first", EVT, mem[0]);
        st(511, 32'h20000000);
        chk("after_stores", 512, stores);
        chk("after_halt", 1, HALT);
        chk("after_last", 32'h200001FE, mem[511]);
        // Pattern-only stop; older locations survive the short run
        do_reset();
        lv(0, {f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE), 8'h00,
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE)}, 515);
        pt(0, tcs_pkg::CMD_STOP, EVT);
        arm();
        st(5, 32'h30000000);
        st(1, EVT);
        chk("stop_halt", 1, HALT);
        chk("stop_stores", 6, stores);
        chk("stop_event", EVT, mem[5]);
        chk("old_kept", 32'h20000005, mem[6]);
        // Precedence and return to level zero in both forms, pattern and always
        do_reset();
        lv(0, {4'h0, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE), 8'h00}, 515);
        lv(1, {4'h0, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE),
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE), 4'h0}, 515);
        pt(1, tcs_pkg::CMD_RET, XR);
        lv(2, {8'h00, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE),
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE)}, 515);
        pt(2, tcs_pkg::CMD_STOP, YS);
        arm();
        st(1, 32'h00000011);
        chk("adv_count", 0, LEVEL_COUNT);
        st(1, XR);
        chk("ret_level", 0, LEVEL);
        chk("ret_count", 0, LEVEL_COUNT);
        st(2, 32'h00000011);
        chk("no_ret_level", 2, LEVEL);
        st(1, 32'h00000022);
        chk("ret_always", 0, LEVEL);
        st(2, 32'h00000011);
        st(1, YS);
        chk("stop_wins", 1, HALT);
        chk("stop_level", 2, LEVEL);
        chk("never_stores", 0, stores);
        // Counted advance, then a silent timed wait
        do_reset();
        lv(0, {4'h0, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_GE), 8'h00}, 3);
        lv(1, {4'h0, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_EQ), 8'h00}, 2);
        arm();
        st(2, 32'h40000000);
        chk("ge_hold", 0, LEVEL);
        chk("ge_count", 2, LEVEL_COUNT);
        st(1, 32'h40000002);
        chk("ge_adv", 1, LEVEL);
        st(1, 32'h40000003);
        chk("eq_hold", 1, LEVEL);
        st(1, 32'h40000004);
        chk("eq_adv", 2, LEVEL);
        chk("eq_stores", 0, stores);
        // Span from a first event through a second event, both kept
        do_reset();
        lv(0, {f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE),
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE), 8'h00}, 515);
        pt(0, tcs_pkg::CMD_ADV, EVT);
        pt(0, tcs_pkg::CMD_TRACE, EVT);
        lv(1, {f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE),
               f(tcs_pkg::COND_PATTERN, tcs_pkg::CNT_NONE), 8'h00}, 515);
        pt(1, tcs_pkg::CMD_ADV, YS);
        lv(2, {8'h00, 4'h0, f(tcs_pkg::COND_ALWAYS, tcs_pkg::CNT_NONE)}, 515);
        arm();
        st(2, 32'h50000000);
        st(1, EVT);
        st(2, 32'h50000010);
        st(1, YS);
        st(1, 32'h50000020);
        chk("span_stores", 4, stores);
        chk("span_halt", 1, HALT);
        chk("span_level", 2, LEVEL);
        chk("span_first", EVT, mem[0]);
        chk("span_last", YS, mem[3]);
        chk("span_kept", 32'h30000004, mem[4]);
        summarize();
    end
endmodule
